// *** flash_pkg.sv ***
// Purpose: Shared constants and types for the flash boot map controller.
// Assumes: 100 MHz hclk; registers reached over AHB-Lite as one aligned word each.
// Notes: The control register keeps its printed offset as an index; byte address is four times it.
package flash_pkg;

   // Clock and operation timing.
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned WRITE_TIME_NS = 2500000;
   localparam int unsigned ERASE_TIME_NS = 5000000;
   // Longest times, rounded down to whole cycles.
   localparam int unsigned WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned ERASE_CYCLES = ERASE_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned TIMER_W = 20;

   // Array geometry and program space split.
   localparam int unsigned FLASH_BYTES = 32768;
   localparam int unsigned FLASH_AW = 15;
   localparam logic [14:0] PAGE_MASK = 15'h001f;
   localparam logic [14:0] BLOCK_MASK = 15'h00ff;
   localparam logic [15:0] BOOT_SPLIT_ADDR = 16'hfc00;
   localparam logic [15:0] INTERNAL_LIMIT = 16'h8000;
   localparam logic [7:0] ERASED_BYTE = 8'hff;

   // Register map (byte addresses, low 12 bits of haddr).
   localparam logic [9:0] FLASH_CONTROL_IDX = 10'h0fb;
   localparam logic [11:0] ADDR_FLASH_CONTROL = {FLASH_CONTROL_IDX, 2'b00};
   localparam logic [11:0] ADDR_DATA_POINTER = 12'h000;
   localparam logic [11:0] ADDR_ACCUMULATOR = 12'h004;
   localparam logic [11:0] ADDR_ROUTINE_CALL = 12'h008;
   localparam logic [11:0] ADDR_STATUS = 12'h00c;

   // Control register fields and reset value.
   localparam int unsigned CTRL_UBS_UPPER = 7;
   localparam int unsigned CTRL_UBS_LOWER = 6;
   localparam int unsigned CTRL_RSV = 4;
   localparam int unsigned CTRL_FC_MSB = 3;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // Function codes.
   localparam logic [3:0] FC_NONE = 4'h0;
   localparam logic [3:0] FC_BYTE = 4'h5;
   localparam logic [3:0] FC_PAGE = 4'hc;
   localparam logic [3:0] FC_BLOCK = 4'h3;
   localparam logic [3:0] FC_FULL = 4'ha;

   // Boot routine entry points.
   localparam logic [15:0] CALL_READ = 16'hffba;
   localparam logic [15:0] CALL_WRITE = 16'hffad;
   localparam logic [15:0] CALL_PAGE = 16'hffaa;
   localparam logic [15:0] CALL_BLOCK = 16'hffa5;
   localparam logic [15:0] CALL_FULL = 16'hffa0;

   // Values left behind by each routine.
   localparam logic [7:0] CTRL_OUT_BYTE = 8'h15;
   localparam logic [7:0] CTRL_OUT_PAGE = 8'h1c;
   localparam logic [7:0] CTRL_OUT_BLOCK = 8'h13;
   localparam logic [7:0] CTRL_OUT_FULL = 8'h1a;
   localparam logic [7:0] ACC_OUT_PAGE = 8'h08;
   localparam logic [7:0] ACC_OUT_BLOCK = 8'h02;
   localparam logic [7:0] ACC_OUT_FULL = 8'h0a;
   localparam logic [7:0] DATA_POINTER_OUT_BLOCK_LOW = 8'h08;
   localparam logic [15:0] DATA_POINTER_OUT_FULL = 16'h0018;

   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_RUN, ST_FINISH} op_state_t;
   typedef enum logic [2:0] {OP_NONE, OP_READ, OP_WRITE, OP_PAGE, OP_BLOCK, OP_FULL} op_kind_t;

   // True where a fetch address is served by the boot ROM.
   function automatic logic boot_mapped(input logic [1:0] ubs, input logic [15:0] addr);
      unique case (ubs)
         2'b00: boot_mapped = 1'b0;
         2'b11: boot_mapped = 1'b1;
         default: boot_mapped = (addr >= BOOT_SPLIT_ADDR);
      endcase
   endfunction

endpackage

// *** flash_op_timer.sv ***
// Purpose: Fixed duration timer for flash write and erase cycles.
// Assumes: Single clock; start is a one-cycle pulse.
// Notes: Has no software access; expired stays high until the next start.
`timescale 1ns/10ps
`default_nettype none
module flash_op_timer #(
   parameter int unsigned W = 20
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Control
   input wire logic start,
   input wire logic [W-1:0] cycles,
   // Status
   output logic expired
);

   typedef struct packed {
      logic [W-1:0] count;
      logic running;
      logic expired;
   } timer_state_t;

   timer_state_t r_reg;
   timer_state_t r_next;

   always_comb begin
      r_next = r_reg;
      if (start) begin
         r_next.count = cycles;
         r_next.running = 1'b1;
         r_next.expired = 1'b0;
      end else if (r_reg.running) begin
         if (r_reg.count <= W'(1)) begin
            r_next.running = 1'b0;
            r_next.expired = 1'b1;
         end
         r_next.count = r_reg.count - W'(1);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign expired = r_reg.expired;

endmodule // flash_op_timer
`default_nettype wire

// *** flash_boot_map_control.sv ***
// Purpose: Flash control register, user/boot program space mapping and boot routine sequencer.
// Assumes: AHB-Lite slave with zero wait states; fetch inputs synchronous to hclk.
// Notes: A write of an entry address to the routine call register stands in for the call.
// Functional notes
// R01 - Erase covers whole array, 256 aligned bytes, or 32 aligned bytes.
// R02 - A byte write finishes within 2.5 ms of internal timing.
// R03 - Any erase finishes within 5 ms; erased bytes read all ones.
// R04 - Select bits 00 map user memory over 64K; execution starts at 0000H.
// R05 - Strobe and access pins low, latch high at reset set both select bits.
// R06 - Select bits 11 map the boot ROM over the whole space.
// R07 - Select bits 01 or 10 split the space at 63K, boot ROM above.
// R08 - Source changes exactly when a fetch crosses the 63K border.
// R09 - Pattern 10 clears the upper select bit once a return lands below 63K.
// R10 - Software never switches memory from code between 63K and 64K.
// R11 - No other flash access or execution while a write or erase runs.
// R12 - Callers disable interrupts before calling a boot routine.
// R13 - High voltage bit is read only and high during write or erase.
// R14 - Software always writes zero to control bit 4.
// R15 - Function codes: 0 reset, 5 byte, c page, 3 block, a full erase.
// R16 - Under security only code from internal flash may change the function code; the code also takes function code a (full erase) from any code.
// R17 - Durations come from an internal timer software cannot control.
// R18 - Caller loads pointer, accumulator, select bits 01, function code, then calls.
// R19 - Routines sit at FFBA, FFAD, FFAA, FFA5 and FFA0.
// R20 - Control register returns 15H, 1CH, 13H or 1AH after each routine.
// R21 - Erase routines leave set accumulator and pointer values.
// R22 - Routines touch only control, accumulator and pointer; write returns read-back.
`timescale 1ns/10ps
`default_nettype none
module flash_boot_map_control #(
   parameter int unsigned WRITE_CYCLES = flash_pkg::WRITE_CYCLES,
   parameter int unsigned ERASE_CYCLES = flash_pkg::ERASE_CYCLES
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Reset straps
   input wire logic program_store_strobe_n,
   input wire logic external_access_n,
   input wire logic address_latch_strobe,
   // Security state from the security byte
   input wire logic security_active,
   // CPU fetch side
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_addr,
   input wire logic ret_taken,
   output logic fetch_boot_sel,
   output logic fetch_hold,
   output logic [7:0] fetch_data,
   // Status
   output logic high_voltage_active
);

   typedef struct packed {
      flash_pkg::op_state_t state;
      flash_pkg::op_kind_t op;
      logic [1:0] ubs;
      logic rsv;
      logic [3:0] fc;
      logic [15:0] data_pointer;
      logic [7:0] acc;
      logic [14:0] sweep;
      logic [14:0] sweep_end;
      logic sweep_done;
      logic strap_done;
      logic strap_boot;
      logic ea_int;
      logic exec_in_flash;
      logic dph_write;
      logic dph_read;
      logic [11:0] dph_addr;
   } ctrl_state_t;

   ctrl_state_t r_reg;
   ctrl_state_t r_next;

   logic [7:0] flash_mem [0:flash_pkg::FLASH_BYTES-1];
   logic [7:0] mem_q;
   logic mem_we;
   logic [14:0] mem_addr;
   logic [7:0] mem_wdata;
   logic timer_start;
   logic [flash_pkg::TIMER_W-1:0] timer_load;
   logic timer_expired;
   logic ahb_take;
   logic boot_strap;
   logic fc_locked;
   logic [7:0] ctrl_read;

   assign ahb_take = hsel && hready && htrans[1];
   assign boot_strap = !program_store_strobe_n && !external_access_n && address_latch_strobe;
   assign fc_locked = security_active && !r_reg.exec_in_flash;

   flash_op_timer #(
      .W(flash_pkg::TIMER_W)
   ) u_timer (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(timer_start),
      .cycles(timer_load),
      .expired(timer_expired) // R17
   );

   always_comb begin
      r_next = r_reg;
      timer_start = 1'b0;
      timer_load = '0;
      mem_we = 1'b0;
      mem_wdata = flash_pkg::ERASED_BYTE;
      mem_addr = fetch_addr[14:0];
      if (!r_reg.strap_done) begin
         r_next.strap_done = 1'b1;
         r_next.ea_int = external_access_n;
         r_next.strap_boot = boot_strap;
         if (boot_strap) begin
            r_next.ubs = 2'b11; // R05
         end
      end
      r_next.dph_write = ahb_take && hwrite;
      r_next.dph_read = ahb_take && !hwrite;
      if (ahb_take) begin
         r_next.dph_addr = haddr[11:0];
      end
      if (fetch_valid) begin
         r_next.exec_in_flash = !fetch_boot_sel && (fetch_addr < flash_pkg::INTERNAL_LIMIT) && r_reg.ea_int;
         if (ret_taken && r_reg.ubs == 2'b10 && fetch_addr < flash_pkg::BOOT_SPLIT_ADDR) begin
            r_next.ubs[1] = 1'b0; // R09
         end
      end
      if (r_reg.dph_write) begin
         if (r_reg.dph_addr == flash_pkg::ADDR_FLASH_CONTROL) begin
            r_next.ubs = {hwdata[flash_pkg::CTRL_UBS_UPPER], hwdata[flash_pkg::CTRL_UBS_LOWER]};
            r_next.rsv = hwdata[flash_pkg::CTRL_RSV];
            if (!fc_locked || hwdata[flash_pkg::CTRL_FC_MSB:0] == flash_pkg::FC_FULL) begin
               r_next.fc = hwdata[flash_pkg::CTRL_FC_MSB:0]; // R16
            end
         end else if (r_reg.state == flash_pkg::ST_IDLE) begin
            if (r_reg.dph_addr == flash_pkg::ADDR_DATA_POINTER) begin
               r_next.data_pointer = hwdata[15:0];
            end else if (r_reg.dph_addr == flash_pkg::ADDR_ACCUMULATOR) begin
               r_next.acc = hwdata[7:0];
            end else if (r_reg.dph_addr == flash_pkg::ADDR_ROUTINE_CALL) begin
               // Entry address and function code must agree, otherwise the call does nothing.
               if (hwdata[15:0] == flash_pkg::CALL_READ && r_reg.fc == flash_pkg::FC_BYTE) begin // R19
                  r_next.op = flash_pkg::OP_READ;
                  r_next.state = flash_pkg::ST_READ;
               end else if (hwdata[15:0] == flash_pkg::CALL_WRITE && r_reg.fc == flash_pkg::FC_BYTE) begin // R15
                  r_next.op = flash_pkg::OP_WRITE;
                  r_next.state = flash_pkg::ST_RUN;
                  timer_start = 1'b1;
                  // The run phase ends one cycle after the expiry flag rises, so the load is one short.
                  timer_load = flash_pkg::TIMER_W'(WRITE_CYCLES - 1); // R02
               end else if (hwdata[15:0] == flash_pkg::CALL_PAGE && r_reg.fc == flash_pkg::FC_PAGE) begin
                  r_next.op = flash_pkg::OP_PAGE;
                  r_next.sweep = r_reg.data_pointer[14:0] & ~flash_pkg::PAGE_MASK; // R01
                  r_next.sweep_end = r_reg.data_pointer[14:0] | flash_pkg::PAGE_MASK;
               end else if (hwdata[15:0] == flash_pkg::CALL_BLOCK && r_reg.fc == flash_pkg::FC_BLOCK) begin
                  r_next.op = flash_pkg::OP_BLOCK;
                  r_next.sweep = r_reg.data_pointer[14:0] & ~flash_pkg::BLOCK_MASK; // R01
                  r_next.sweep_end = r_reg.data_pointer[14:0] | flash_pkg::BLOCK_MASK;
               end else if (hwdata[15:0] == flash_pkg::CALL_FULL && r_reg.fc == flash_pkg::FC_FULL) begin
                  r_next.op = flash_pkg::OP_FULL;
                  r_next.sweep = '0; // R01
                  r_next.sweep_end = '1;
               end
               if (r_next.op inside {flash_pkg::OP_PAGE, flash_pkg::OP_BLOCK, flash_pkg::OP_FULL}) begin
                  r_next.state = flash_pkg::ST_RUN;
                  r_next.sweep_done = 1'b0;
                  timer_start = 1'b1;
                  timer_load = flash_pkg::TIMER_W'(ERASE_CYCLES - 1); // R03
               end
            end
         end
      end
      unique case (r_reg.state)
         flash_pkg::ST_IDLE: begin
         end
         flash_pkg::ST_READ: begin
            mem_addr = r_reg.data_pointer[14:0];
            r_next.state = flash_pkg::ST_FINISH;
         end
         flash_pkg::ST_RUN: begin
            if (r_reg.op == flash_pkg::OP_WRITE) begin
               mem_addr = r_reg.data_pointer[14:0];
               if (timer_expired) begin
                  r_next.state = flash_pkg::ST_FINISH;
               end
            end else begin
               // One byte per cycle is cleared; the sweep ends long before the erase time.
               mem_addr = r_reg.sweep;
               mem_we = !r_reg.sweep_done; // R03
               if (!r_reg.sweep_done) begin
                  r_next.sweep = r_reg.sweep + 15'h0001;
                  r_next.sweep_done = (r_reg.sweep == r_reg.sweep_end);
               end
               if (timer_expired && r_reg.sweep_done) begin
                  r_next.state = flash_pkg::ST_FINISH;
               end
            end
         end
         flash_pkg::ST_FINISH: begin
            r_next.state = flash_pkg::ST_IDLE;
            r_next.op = flash_pkg::OP_NONE;
            unique case (r_reg.op)
               flash_pkg::OP_READ: begin
                  r_next.acc = mem_q;
                  {r_next.ubs, r_next.rsv, r_next.fc} = {flash_pkg::CTRL_OUT_BYTE[7:6], flash_pkg::CTRL_OUT_BYTE[4:0]}; // R20
               end
               flash_pkg::OP_WRITE: begin
                  // Programming only clears bits, so the stored byte is the AND with the old one.
                  mem_addr = r_reg.data_pointer[14:0];
                  mem_we = 1'b1;
                  mem_wdata = r_reg.acc & mem_q;
                  r_next.acc = r_reg.acc & mem_q; // R22
                  {r_next.ubs, r_next.rsv, r_next.fc} = {flash_pkg::CTRL_OUT_BYTE[7:6], flash_pkg::CTRL_OUT_BYTE[4:0]}; // R20
               end
               flash_pkg::OP_PAGE: begin
                  r_next.acc = flash_pkg::ACC_OUT_PAGE; // R21
                  r_next.data_pointer[4:0] = 5'h00;
                  {r_next.ubs, r_next.rsv, r_next.fc} = {flash_pkg::CTRL_OUT_PAGE[7:6], flash_pkg::CTRL_OUT_PAGE[4:0]}; // R20
               end
               flash_pkg::OP_BLOCK: begin
                  r_next.acc = flash_pkg::ACC_OUT_BLOCK; // R21
                  r_next.data_pointer[7:0] = flash_pkg::DATA_POINTER_OUT_BLOCK_LOW;
                  {r_next.ubs, r_next.rsv, r_next.fc} = {flash_pkg::CTRL_OUT_BLOCK[7:6], flash_pkg::CTRL_OUT_BLOCK[4:0]};
               end
               flash_pkg::OP_FULL: begin
                  r_next.acc = flash_pkg::ACC_OUT_FULL;
                  r_next.data_pointer = flash_pkg::DATA_POINTER_OUT_FULL; // R21
                  {r_next.ubs, r_next.rsv, r_next.fc} = {flash_pkg::CTRL_OUT_FULL[7:6], flash_pkg::CTRL_OUT_FULL[4:0]};
               end
               default: begin
               end
            endcase
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r_reg <= '0;
         r_reg.ubs <= flash_pkg::CTRL_RESET[7:6];
         r_reg.fc <= flash_pkg::CTRL_RESET[3:0];
      end else begin
         r_reg <= r_next;
      end
   end

   always_ff @(posedge hclk) begin
      if (mem_we) begin
         flash_mem[mem_addr] <= mem_wdata;
      end
      mem_q <= flash_mem[mem_addr];
   end

   // Mapping is a pure decode of the fetch address, so the source flips on the crossing fetch itself.
   assign fetch_boot_sel = flash_pkg::boot_mapped(r_reg.ubs, fetch_addr); // R04 R06 R07 R08
   assign fetch_hold = (r_reg.state != flash_pkg::ST_IDLE) && !fetch_boot_sel &&
                       (fetch_addr < flash_pkg::INTERNAL_LIMIT) && r_reg.ea_int; // R11
   assign fetch_data = mem_q;
   assign high_voltage_active = (r_reg.state == flash_pkg::ST_RUN); // R13
   assign ctrl_read = {r_reg.ubs, high_voltage_active, r_reg.rsv, r_reg.fc};

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   always_comb begin
      hrdata = 32'h0000_0000;
      if (r_reg.dph_read) begin
         unique case (r_reg.dph_addr)
            flash_pkg::ADDR_FLASH_CONTROL: hrdata = {24'h000000, ctrl_read};
            flash_pkg::ADDR_DATA_POINTER: hrdata = {16'h0000, r_reg.data_pointer};
            flash_pkg::ADDR_ACCUMULATOR: hrdata = {24'h000000, r_reg.acc};
            flash_pkg::ADDR_STATUS: hrdata = {28'h0000000, security_active, r_reg.ea_int, r_reg.strap_boot,
                                              r_reg.state != flash_pkg::ST_IDLE};
            default: hrdata = 32'h0000_0000;
         endcase
      end
   end

   // Length of the current run phase, for the timing checks.
   logic [flash_pkg::TIMER_W-1:0] run_cycles;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_cycles <= '0;
      end else if (r_reg.state == flash_pkg::ST_RUN) begin
         run_cycles <= run_cycles + flash_pkg::TIMER_W'(1);
      end else begin
         run_cycles <= '0;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence seq_page_finish;
      r_reg.state == flash_pkg::ST_FINISH && r_reg.op == flash_pkg::OP_PAGE;
   endsequence

   sequence seq_locked_fc_write;
      r_reg.dph_write && r_reg.dph_addr == flash_pkg::ADDR_FLASH_CONTROL && fc_locked &&
      hwdata[3:0] != flash_pkg::FC_FULL;
   endsequence

   chk_user_full_map: assert property (r_reg.ubs == 2'b00 |-> !fetch_boot_sel) // R04
      else $error("boot ROM selected with select bits 00");
   chk_boot_full_map: assert property (r_reg.ubs == 2'b11 |-> fetch_boot_sel) // R06
      else $error("user memory selected with select bits 11");
   chk_split_map: assert property (r_reg.ubs inside {2'b01, 2'b10} |-> // R07
      fetch_boot_sel == (fetch_addr >= 16'hfc00))
      else $error("split map decodes the 63K border wrongly");
   chk_strap_boot: assert property (!r_reg.strap_done && boot_strap |=> r_reg.ubs == 2'b11) // R05
      else $error("boot strap did not set both select bits");
   chk_boot_select_upper_clear: assert property (fetch_valid && ret_taken && r_reg.ubs == 2'b10 && fetch_addr < 16'hfc00 && // R09
      r_reg.strap_done && !r_reg.dph_write && r_reg.state == flash_pkg::ST_IDLE |=> r_reg.ubs == 2'b00)
      else $error("upper select bit not cleared after return below 63K");
   chk_hv_run: assert property (high_voltage_active == (r_reg.state != flash_pkg::ST_FINISH && // R13
      r_reg.op inside {flash_pkg::OP_WRITE, flash_pkg::OP_PAGE, flash_pkg::OP_BLOCK, flash_pkg::OP_FULL}))
      else $error("high voltage flag disagrees with run phase");
   chk_fetch_hold: assert property (r_reg.state == flash_pkg::ST_RUN && r_reg.ea_int && r_reg.ubs != 2'b11 && // R11
      fetch_addr < 16'h8000 |-> fetch_hold)
      else $error("flash fetch not held during write or erase");
   // The counter reads one less than the cycles spent in the run phase.
   chk_write_time: assert property (r_reg.state == flash_pkg::ST_RUN && r_reg.op == flash_pkg::OP_WRITE && // R02
      r_next.state == flash_pkg::ST_FINISH |-> run_cycles == flash_pkg::TIMER_W'(WRITE_CYCLES - 1))
      else $error("byte write run length differs from write time");
   chk_page_result: assert property (seq_page_finish |=> r_reg.acc == 8'h08 && r_reg.data_pointer[4:0] == 5'h00 && // R21
      ctrl_read == 8'h1c)
      else $error("page erase left wrong accumulator, pointer or control value");
   chk_secure_fc: assert property (seq_locked_fc_write |=> $stable(r_reg.fc)) // R16
      else $error("function code changed by locked code while secure");

endmodule // flash_boot_map_control
`default_nettype wire

// *** cpu_fetch_model.sv ***
// Purpose: CPU core stand-in that issues program fetches.
// Assumes: Changes its outputs just after a rising edge of hclk.
// Notes: Idle address lines show the inverse of the last address.
`timescale 1ns/10ps
`default_nettype none
module cpu_fetch_model (
   // Clock
   input wire logic hclk,
   // Answers from the map
   input wire logic fetch_boot_sel,
   input wire logic fetch_hold,
   // Fetch requests
   output logic fetch_valid,
   output logic [15:0] fetch_addr,
   output logic ret_taken
);
   initial begin
      fetch_valid = 1'b0;
      fetch_addr = 16'h0000;
      ret_taken = 1'b0;
   end
   // No interrupts are ever taken, and no switch is made from code above 63K.
   task automatic fetch(input logic [15:0] a, input logic r, output logic sel, output logic hold);
      @(posedge hclk);
      fetch_valid <= 1'b1;
      fetch_addr <= a;
      ret_taken <= r;
      #2;
      sel = fetch_boot_sel;
      hold = fetch_hold;
      @(posedge hclk);
      fetch_valid <= 1'b0;
      ret_taken <= 1'b0;
      fetch_addr <= ~a;
   endtask
endmodule // cpu_fetch_model
`default_nettype wire

// *** test_flash_boot_map_control.sv ***
// Purpose: Self-checking bench for the flash boot map controller.
// Assumes: hclk at 100 MHz; short timer parameters.
// Notes: Expected values come from a bench model of the array.
`timescale 1ns/10ps
`default_nettype none
module test_flash_boot_map_control;
   localparam int WC = 20;
   localparam logic [11:0] CT = flash_pkg::ADDR_FLASH_CONTROL, DP = flash_pkg::ADDR_DATA_POINTER;
   localparam logic [11:0] AC = flash_pkg::ADDR_ACCUMULATOR, CL = flash_pkg::ADDR_ROUTINE_CALL;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, sec = 1'b0, pss_n = 1'b1, ea_n = 1'b1, ale = 1'b1;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, lfsr = 32'h44f8eac6;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'h2;
   logic hready, hreadyout, hresp, fv, rt, bsel, hold, hv, s, h;
   logic [15:0] fa, pa;
   logic [7:0] fd;
   int mismatches = 0, n_compared = 0, hv_cnt = 0;
   int mem[int];
   always #5 hclk = ~hclk;
   assign hready = hreadyout;
   always @(posedge hclk) if (hv === 1'b1) hv_cnt++;
   flash_boot_map_control #(.WRITE_CYCLES(WC), .ERASE_CYCLES(40)) i_dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .program_store_strobe_n(pss_n),
      .external_access_n(ea_n), .address_latch_strobe(ale), .security_active(sec), .fetch_valid(fv),
      .fetch_addr(fa), .ret_taken(rt), .fetch_boot_sel(bsel), .fetch_hold(hold), .fetch_data(fd),
      .high_voltage_active(hv));
   cpu_fetch_model i_cpu (.hclk(hclk), .fetch_boot_sel(bsel), .fetch_hold(hold), .fetch_valid(fv),
      .fetch_addr(fa), .ret_taken(rt));
   task automatic conclude;
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: register %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: fetch or status bit %b, expected %b", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic wait_rdy;
      int k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hready !== 1'b1 && k < 64);
      if (hready !== 1'b1 || hresp !== 1'b0) begin
         mismatches++;
         $display("wrong value at %0t: bus stalled or error response", $time);
         conclude();
      end
   endtask
   // One single word transfer; called just after a rising edge.
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk_reg(rd, e);
   endtask
   task automatic fchk(input logic [15:0] a, input logic r, input logic eb);
      i_cpu.fetch(a, r, s, h);
      chk_bit(s, eb);
   endtask
   task automatic do_reset(input logic p);
      pss_n <= p;
      ea_n <= p;
      hresetn <= 1'b0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
   endtask
   task automatic run(input logic [3:0] fc, input logic [15:0] entry, input logic [15:0] a, input logic [7:0] d);
      logic [7:0] old, ea;
      logic [15:0] ep;
      int sp, n;
      old = 8'hxx;
      if (mem.exists(a)) old = 8'(mem[a]);
      ep = a;
      ea = old;
      if (entry == 16'hffad) begin
         ea = old & d;
         mem[a] = ea;
      end
      sp = fc == 4'hc ? 32 : fc == 4'h3 ? 256 : 32768;
      if (fc != 4'h5) for (n = 0; n < sp; n++) mem[(a & ~(sp - 1)) + n] = 255;
      case (fc)
         4'hc: begin
            ea = 8'h08;
            ep = a & 16'hffe0;
         end
         4'h3: begin
            ea = 8'h02;
            ep = {a[15:8], 8'h08};
         end
         4'ha: begin
            ea = 8'h0a;
            ep = 16'h0018;
         end
         default: ;
      endcase
      wr(DP, {16'h0, a});
      wr(AC, {24'h0, d});
      wr(CT, {24'h0, 4'h4, fc});
      wr(CL, {16'h0, entry});
      hv_cnt = 0;
      if (entry != 16'hffba) i_cpu.fetch(16'h0100, 1'b0, s, h);
      if (entry != 16'hffba) chk_bit(h, 1'b1);
      n = 0;
      do begin
         bus(1'b0, flash_pkg::ADDR_STATUS, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 40000);
      if (n >= 40000) begin
         chk_bit(1'b1, 1'b0);
         conclude();
      end
      chk_bit(hv_cnt > 0, entry != 16'hffba);
      if (entry == 16'hffad) chk_bit(hv_cnt <= WC, 1'b1);
      rdc(CT, {24'h0, 4'h1, fc});
      rdc(AC, {24'h0, ea});
      rdc(DP, {16'h0, ep});
   endtask
   logic [15:0] ad[4] = '{16'h0000, 16'hfbff, 16'hfc00, 16'hffff};
   initial begin
      ale <= 1'b0;
      do_reset(1'b0);
      rdc(CT, 32'h00);
      ale <= 1'b1;
      do_reset(1'b0);
      rdc(CT, 32'hc0);
      rdc(flash_pkg::ADDR_STATUS, 32'h2);
      fchk(16'h5000, 1'b0, 1'b1);
      do_reset(1'b1);
      rdc(CT, 32'h00);
      rdc(flash_pkg::ADDR_STATUS, 32'h4);
      fchk(16'h0000, 1'b0, 1'b0);
      rdc(12'h100, 32'h0);
      sec <= 1'b1;
      wr(CT, 32'h40);
      fchk(16'hfc00, 1'b0, 1'b1);
      wr(CT, 32'h45);
      rdc(CT, 32'h40);
      wr(CT, 32'h4a);
      rdc(CT, 32'h4a);
      fchk(16'h0100, 1'b0, 1'b0);
      wr(CT, 32'h45);
      rdc(CT, 32'h45);
      sec <= 1'b0;
      wr(CT, 32'h25);
      rdc(CT, 32'h05);
      for (int u = 0; u < 4; u++) foreach (ad[i]) begin
         wr(CT, {24'h0, u[1:0], 6'h0});
         fchk(ad[i], 1'b0, u == 3 || (u != 0 && ad[i] >= 16'hfc00));
      end
      wr(CT, 32'h80);
      fchk(16'hfc10, 1'b0, 1'b1);
      fchk(16'h1000, 1'b1, 1'b0);
      rdc(CT, 32'h00);
      lfsr = lfsr_next(lfsr);
      pa = {4'h1, lfsr[11:8], 8'h00};
      run(4'h3, 16'hffa5, pa + 16'h0011, lfsr[7:0]);
      run(4'h5, 16'hffad, pa + 16'h0023, lfsr[23:16]);
      run(4'h5, 16'hffad, pa + 16'h0045, lfsr[31:24]);
      run(4'hc, 16'hffaa, pa + 16'h0040 + 16'(lfsr[4:0]), 8'h00);
      run(4'h5, 16'hffba, pa + 16'h0023, 8'h00);
      i_cpu.fetch(pa + 16'h0023, 1'b0, s, h);
      #1 chk_reg({24'h0, fd}, mem[pa + 16'h0023]);
      @(posedge hclk);
      run(4'h5, 16'hffba, pa + 16'h0045, 8'h00);
      run(4'ha, 16'hffa0, pa, 8'h00);
      run(4'h5, 16'hffba, pa + 16'h0023, 8'h00);
      conclude();
   end
endmodule // test_flash_boot_map_control
`default_nettype wire
